// ---- common/tcm_defs.vh ----
// Register offsets, field positions, reset values and codes for the timer channel block
`ifndef TCM_DEFS_VH
`define TCM_DEFS_VH

// Register offsets (chosen map, byte addresses)
`define TCM_ADDR_MODE 4'h0
`define TCM_ADDR_MASK 4'h4
`define TCM_ADDR_REQ 4'h5
`define TCM_ADDR_PRIH 4'h6
`define TCM_ADDR_PRIL 4'h7
`define TCM_ADDR_CTRL 4'h8
`define TCM_ADDR_STAT 4'h9
`define TCM_ADDR_RELOAD 4'hA
`define TCM_ADDR_COUNT 4'hB

// Field positions
`define TCM_CH0_BIT 4
`define TCM_CKS_HI 15
`define TCM_CKS_LO 14
`define TCM_CCS_BIT 12
`define TCM_STS_HI 10
`define TCM_STS_LO 8
`define TCM_CIS_HI 7
`define TCM_CIS_LO 6
`define TCM_MD_HI 3
`define TCM_MD_LO 1
`define TCM_MD0_BIT 0

// Writable bits of the mode register: 13, 11, 5 and 4 stay zero
`define TCM_MODE_WMASK 16'hD7CF
`define TCM_MODE_RESET 16'h0000
`define TCM_MASK_RESET 8'hFF
`define TCM_REQ_RESET 8'h00
`define TCM_PRI_RESET 8'hFF

// Trigger codes
`define TCM_STS_SOFT 3'h0
`define TCM_STS_EDGE 3'h1
`define TCM_STS_BOTH 3'h2
`define TCM_STS_MASTER 3'h4

// Mode codes
`define TCM_MD_INTERVAL 3'h0
`define TCM_MD_CAPTURE 3'h2
`define TCM_MD_EVENT 3'h3
`define TCM_MD_ONECOUNT 3'h4
`define TCM_MD_CAPONE 3'h6

// Control bits
`define TCM_CTRL_START 0
`define TCM_CTRL_STOP 1

`endif

// ---- design/tcm_edge_detect.v ----
// Pin synchroniser and valid edge detector for the timer input
`timescale 1ns/1ns
`default_nettype none
module tcm_edge_detect (
  // Clock and reset
  input wire mclk,
  input wire reset,
  // Sampling enable (operation clock tick)
  input wire sample_en,
  // Edge selection: 0 rising, 1 falling, 2 both
  input wire [1:0] edge_sel,
  // Pin and result
  input wire pin_in,
  output reg edge_pulse
);
  reg [2:0] sync_q;
  reg level_q;
  wire agree;

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      sync_q <= 3'h0;
    end else begin
      sync_q <= {sync_q[1:0], pin_in};
    end
  end

  // Change counts once stages two and three agree
  assign agree = (sync_q[1] == sync_q[2]);

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      level_q <= 1'b0;
      edge_pulse <= 1'b0;
    end else begin
      edge_pulse <= 1'b0;
      if (sample_en && agree && (sync_q[2] != level_q)) begin
        level_q <= sync_q[2];
        case (edge_sel)
          2'h0: edge_pulse <= sync_q[2];
          2'h1: edge_pulse <= ~sync_q[2];
          default: edge_pulse <= 1'b1;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ---- design/tcm_channel.v ----
// Timer channel zero: mode register, clock and trigger selection, counter, interrupt flags
// ************************************************************
// Notes on behaviour
// ************************************************************
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "tcm_defs.vh"
module tcm_channel #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input wire mclk,
  input wire reset,
  // Register port
  input wire [3:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  output reg [15:0] rdata,
  // Prescaler tick inputs, one per output, in mclk domain
  input wire [3:0] prescaler_tick,
  // Timer input pin and master channel interrupt
  input wire timer_input_pin,
  input wire master_irq,
  // Results
  output reg timer_out,
  output reg [WIDTH-1:0] capture_q,
  output wire irq_service,
  output wire [1:0] irq_level,
  output wire config_error
);
  // ************************************************************
  // Registers
  // ************************************************************
  reg [15:0] mode_q;
  reg [7:0] mask_q;
  reg [7:0] req_q;
  reg [7:0] prih_q;
  reg [7:0] pril_q;
  reg [WIDTH-1:0] reload_q;
  reg [WIDTH-1:0] count_q;
  reg running_q;
  reg set_req;
  wire [2:0] sts;
  wire [2:0] md;
  wire md0;
  wire start_sw;
  wire stop_sw;

  assign sts = mode_q[`TCM_STS_HI:`TCM_STS_LO];
  assign md = mode_q[`TCM_MD_HI:`TCM_MD_LO];
  assign md0 = mode_q[`TCM_MD0_BIT];
  assign start_sw = wr && (addr == `TCM_ADDR_CTRL) && wdata[`TCM_CTRL_START];
  assign stop_sw = wr && (addr == `TCM_ADDR_CTRL) && wdata[`TCM_CTRL_STOP];

  // ************************************************************
  // Operation clock and count clock
  // ************************************************************
  reg op_tick;
  wire pin_edge;
  wire count_tick;

  always @* begin
    case (mode_q[`TCM_CKS_HI:`TCM_CKS_LO])
      2'h0: op_tick = prescaler_tick[0];
      2'h2: op_tick = prescaler_tick[1];
      // Outputs 2 and 3 belong to channels 1 and 3 only
      default: op_tick = 1'b0;
    endcase
  end

  tcm_edge_detect u_edge (
    .mclk(mclk),
    .reset(reset),
    .sample_en(op_tick),
    .edge_sel((sts == `TCM_STS_BOTH) ? 2'h2 : mode_q[`TCM_CIS_HI:`TCM_CIS_LO]),
    .pin_in(timer_input_pin),
    .edge_pulse(pin_edge)
  );

  // Count clock: operation clock or pin valid edge
  assign count_tick = mode_q[`TCM_CCS_BIT] ? pin_edge : op_tick;

  // ************************************************************
  // Mode and trigger decode
  // ************************************************************
  reg mode_ok;
  reg count_up;
  reg start_irq;
  reg retrig_ok;
  reg trig_ok;
  reg hw_trig;
  reg capture_ok;

  always @* begin
    mode_ok = 1'b1;
    count_up = 1'b0;
    start_irq = 1'b0;
    retrig_ok = 1'b0;
    capture_ok = 1'b0;
    case (md)
      `TCM_MD_INTERVAL: start_irq = md0;
      `TCM_MD_CAPTURE: begin
        count_up = 1'b1;
        capture_ok = 1'b1;
        start_irq = md0;
      end
      `TCM_MD_EVENT: start_irq = md0;
      `TCM_MD_ONECOUNT: retrig_ok = md0;
      `TCM_MD_CAPONE: begin
        count_up = 1'b1;
        mode_ok = ~md0;
      end
      default: mode_ok = 1'b0;
    endcase
  end

  always @* begin
    trig_ok = 1'b1;
    hw_trig = 1'b0;
    case (sts)
      `TCM_STS_SOFT: hw_trig = 1'b0;
      `TCM_STS_EDGE: hw_trig = pin_edge;
      `TCM_STS_BOTH: hw_trig = pin_edge;
      `TCM_STS_MASTER: hw_trig = master_irq;
      default: trig_ok = 1'b0;
    endcase
  end

  assign config_error = ~mode_ok | ~trig_ok;

  // ************************************************************
  // Counter
  // ************************************************************
  wire trigger;
  wire accept;
  wire at_end;

  assign trigger = start_sw | hw_trig;
  // While running: capture mode captures, one-count with bit 0 set retriggers
  assign accept = trigger && mode_ok && trig_ok && (~running_q || retrig_ok || capture_ok);
  assign at_end = count_up ? (count_q == reload_q) : (count_q == {WIDTH{1'b0}});

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      count_q <= {WIDTH{1'b0}};
      running_q <= 1'b0;
      timer_out <= 1'b0;
      capture_q <= {WIDTH{1'b0}};
      set_req <= 1'b0;
    end else begin
      set_req <= 1'b0;
      if (stop_sw) begin
        running_q <= 1'b0;
      end else if (accept) begin
        running_q <= 1'b1;
        count_q <= count_up ? {WIDTH{1'b0}} : reload_q;
        if (running_q || start_irq) begin
          set_req <= 1'b1;
        end
        if (start_irq) begin
          timer_out <= ~timer_out;
        end
        if (count_up && running_q) begin
          capture_q <= count_q;
        end
      end else if (running_q && count_tick) begin
        if (at_end) begin
          set_req <= 1'b1;
          timer_out <= ~timer_out;
          if (md == `TCM_MD_ONECOUNT || md == `TCM_MD_CAPONE) begin
            running_q <= 1'b0;
          end else begin
            count_q <= count_up ? {WIDTH{1'b0}} : reload_q;
          end
        end else if (count_up) begin
          count_q <= count_q + 1'b1;
        end else begin
          count_q <= count_q - 1'b1;
        end
      end
    end
  end

  // ************************************************************
  // Register writes
  // ************************************************************
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      mode_q <= `TCM_MODE_RESET;
      mask_q <= `TCM_MASK_RESET;
      req_q <= `TCM_REQ_RESET;
      prih_q <= `TCM_PRI_RESET;
      pril_q <= `TCM_PRI_RESET;
      reload_q <= {WIDTH{1'b0}};
    end else begin
      if (wr && addr == `TCM_ADDR_MODE) begin
        mode_q <= wdata & `TCM_MODE_WMASK;
      end
      if (wr && addr == `TCM_ADDR_MASK) begin
        mask_q <= wdata[7:0];
      end
      if (wr && addr == `TCM_ADDR_PRIH) begin
        prih_q <= wdata[7:0];
      end
      if (wr && addr == `TCM_ADDR_PRIL) begin
        pril_q <= wdata[7:0];
      end
      if (wr && addr == `TCM_ADDR_RELOAD) begin
        reload_q <= wdata[WIDTH-1:0];
      end
      // Hardware set wins over a software clear in the same cycle
      if (wr && addr == `TCM_ADDR_REQ) begin
        req_q <= wdata[7:0];
      end
      if (set_req) begin
        req_q[`TCM_CH0_BIT] <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Interrupt outputs
  // ************************************************************
  assign irq_service = req_q[`TCM_CH0_BIT] & ~mask_q[`TCM_CH0_BIT];
  assign irq_level = {prih_q[`TCM_CH0_BIT], pril_q[`TCM_CH0_BIT]};

  // ************************************************************
  // Read port
  // ************************************************************
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      if (addr == `TCM_ADDR_MODE) begin
        rdata <= mode_q;
      end else if (addr == `TCM_ADDR_MASK) begin
        rdata <= {8'h00, mask_q};
      end else if (addr == `TCM_ADDR_REQ) begin
        rdata <= {8'h00, req_q};
      end else if (addr == `TCM_ADDR_PRIH) begin
        rdata <= {8'h00, prih_q};
      end else if (addr == `TCM_ADDR_PRIL) begin
        rdata <= {8'h00, pril_q};
      end else if (addr == `TCM_ADDR_STAT) begin
        rdata <= {13'h0000, config_error, timer_out, running_q};
      end else if (addr == `TCM_ADDR_RELOAD) begin
        rdata <= reload_q;
      end else if (addr == `TCM_ADDR_COUNT) begin
        rdata <= count_q;
      end else begin
        rdata <= 16'h0000;
      end
    end else begin
      rdata <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// ---- tb/tcm_channel_assertions.sv ----
// Port-level assertions for the timer channel register and interrupt behaviour
`timescale 1ns/1ns
`default_nettype none
module tcm_channel_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  // Results
  input wire logic irq_service,
  input wire logic [1:0] irq_level,
  input wire logic config_error
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // ************************************************************
  // Register and interrupt relations
  // ************************************************************
  mask_blocks_a: assert property (wr && addr == 4'h4 && wdata[4] |=> !irq_service)
    else $error("service seen with mask set");
  mask_read_a: assert property (rd && addr == 4'h4 && irq_service |=> !rdata[4])
    else $error("mask bit reads set while serviced");
  req_read_a: assert property (rd && addr == 4'h5 && irq_service |=> rdata[4])
    else $error("request bit reads clear while pending");
  pri_high_a: assert property (wr && addr == 4'h6 |=> irq_level[1] == $past(wdata[4]))
    else $error("level high bit wrong");
  pri_low_a: assert property (wr && addr == 4'h7 |=> irq_level[0] == $past(wdata[4]))
    else $error("level low bit wrong");
  pri_read_a: assert property (rd && addr == 4'h6 |=> rdata[4] == $past(irq_level[1]))
    else $error("priority read differs from level");
  trig_prohib_a: assert property (wr && addr == 4'h0 && wdata[10:8] inside {3'h3, 3'h5, 3'h6, 3'h7}
    |=> config_error)
    else $error("prohibited trigger not flagged");
  mode_prohib_a: assert property (wr && addr == 4'h0 && wdata[3:1] inside {3'h1, 3'h5, 3'h7}
    |=> config_error)
    else $error("prohibited mode not flagged");
  mode_zero_a: assert property (rd && addr == 4'h0 |=> (rdata & 16'h2830) == 16'h0000)
    else $error("fixed mode bits read nonzero");
endmodule
bind tcm_channel tcm_channel_chk u_chk (.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .irq_service(irq_service), .irq_level(irq_level),
  .config_error(config_error));
`default_nettype wire

// ---- tb/tb.sv ----
// Register-level testbench for the timer channel block
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic mclk, reset, wr, rd, pin, master_irq;
  logic [3:0] addr, tick;
  logic [15:0] wdata;
  wire [15:0] rdata;
  wire [1:0] irq_level;
  wire irq_service, config_error, tout;
  wire [15:0] capq;
  int fail_count, n_compared, i;
  logic t0;

  tcm_channel DUT (.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .prescaler_tick(tick), .timer_input_pin(pin), .master_irq(master_irq),
    .timer_out(tout), .capture_q(capq), .irq_service(irq_service), .irq_level(irq_level),
    .config_error(config_error));

  // ************************************************************
  // Access tasks
  // ************************************************************
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [3:0] a, input logic [15:0] e, input string nm);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk(nm, e, rdata);
  endtask
  // Stop, clear flag, configure, start, run, stop, then read the flag
  task automatic run(input logic [15:0] m, input logic [3:0] t, input logic p,
                     input logic [15:0] e, input string nm);
    wr_reg(4'h8, 16'h0002);
    wr_reg(4'h5, 16'h0000);
    wr_reg(4'hA, 16'h0002);
    wr_reg(4'h0, m);
    wr_reg(4'h8, 16'h0001);
    @(posedge mclk) tick <= t;
    repeat (16) begin
      repeat (3) @(posedge mclk);
      pin <= p & ~pin;
    end
    tick <= 4'h0;
    wr_reg(4'h8, 16'h0002);
    rchk(4'h5, e, nm);
  endtask
  // Count after start and after one tick, then a second start for capture
  task automatic dir_chk(input logic [15:0] m, input logic [15:0] e0, input logic [15:0] e1,
                         input logic [15:0] ec, input string nm);
    wr_reg(4'h8, 16'h0002);
    wr_reg(4'hA, 16'h0005);
    wr_reg(4'h0, m);
    wr_reg(4'h8, 16'h0001);
    rchk(4'hB, e0, nm);
    @(posedge mclk) tick <= 4'h1;
    @(posedge mclk) tick <= 4'h0;
    rchk(4'hB, e1, nm);
    wr_reg(4'h8, 16'h0001);
    chk(nm, ec, capq);
  endtask
  // Hardware triggers only: pin toggles, then one master pulse
  task automatic hw_run(input logic [15:0] m, input logic p, input logic mi,
                        input logic [15:0] e, input string nm);
    wr_reg(4'h8, 16'h0002);
    wr_reg(4'h5, 16'h0000);
    wr_reg(4'h0, m);
    @(posedge mclk) tick <= 4'h1;
    repeat (4) begin
      repeat (3) @(posedge mclk);
      pin <= p & ~pin;
    end
    @(posedge mclk) master_irq <= mi;
    @(posedge mclk) master_irq <= 1'b0;
    tick <= 4'h0;
    wr_reg(4'h8, 16'h0002);
    rchk(4'h5, e, nm);
  endtask
  // Two software starts while the counter stands still
  task automatic retrig(input logic [15:0] m, input logic [15:0] e, input string nm);
    wr_reg(4'h8, 16'h0002);
    wr_reg(4'h5, 16'h0000);
    wr_reg(4'h0, m);
    wr_reg(4'h8, 16'h0001);
    wr_reg(4'h8, 16'h0001);
    rchk(4'h5, e, nm);
  endtask
  task automatic final_report;
    if (fail_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // Whole sequence is under a thousand cycles
  initial begin
    #200000;
    fail_count++;
    final_report();
  end

  initial begin
    reset = 1'b1;
    {wr, rd, pin, master_irq, addr, tick, wdata} = '0;
    fail_count = 0;
    n_compared = 0;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    rchk(4'h4, 16'h00FF, "mask reset");
    rchk(4'h5, 16'h0000, "request reset");
    rchk(4'h6, 16'h00FF, "prio high reset");
    rchk(4'h7, 16'h00FF, "prio low reset");
    rchk(4'h0, 16'h0000, "mode reset");
    rchk(4'hF, 16'h0000, "unmapped read");
    chk("out reset", 16'h0, {15'h0, tout});
    wr_reg(4'h0, 16'hFFFF);
    rchk(4'h0, 16'hD7CF, "mode fixed bits");
    for (i = 0; i < 8; i++) begin
      wr_reg(4'h0, {5'h0, i[2:0], 8'h00});
      chk("trigger code", (i == 3 || i > 4) ? 16'h1 : 16'h0, {15'h0, config_error});
      wr_reg(4'h0, {12'h0, i[2:0], 1'b0});
      chk("mode code", (i == 1 || i == 5 || i == 7) ? 16'h1 : 16'h0, {15'h0, config_error});
    end
    for (i = 0; i < 4; i++) begin
      wr_reg(4'h6, i[1] ? 16'h0010 : 16'h0000);
      wr_reg(4'h7, i[0] ? 16'h0010 : 16'h0000);
      chk("level", i[15:0], {14'h0, irq_level});
    end
    run(16'h0000, 4'h1, 1'b0, 16'h0010, "interval end");
    wr_reg(4'h4, 16'h00EF);
    chk("service unmasked", 16'h1, {15'h0, irq_service});
    wr_reg(4'h4, 16'h00FF);
    chk("service masked", 16'h0, {15'h0, irq_service});
    rchk(4'h5, 16'h0010, "flag held masked");
    run(16'h4000, 4'hF, 1'b0, 16'h0000, "clock code 01");
    run(16'h8000, 4'h2, 1'b0, 16'h0010, "clock code 10");
    run(16'h8000, 4'h1, 1'b0, 16'h0000, "clock code 10 idle");
    run(16'h1000, 4'h1, 1'b0, 16'h0000, "pin still");
    run(16'h1000, 4'h1, 1'b1, 16'h0010, "pin edges");
    run(16'h0001, 4'h0, 1'b0, 16'h0010, "start irq on");
    run(16'h0000, 4'h0, 1'b0, 16'h0000, "start irq off");
    run(16'hC000, 4'hF, 1'b0, 16'h0000, "clock code 11");
    t0 = tout;
    wr_reg(4'h0, 16'h0001);
    wr_reg(4'h8, 16'h0001);
    chk("out on start", {15'h0, ~t0}, {15'h0, tout});
    rchk(4'h9, {14'h0, ~t0, 1'b1}, "status running");
    wr_reg(4'h8, 16'h0002);
    wr_reg(4'h0, 16'h0000);
    wr_reg(4'h8, 16'h0001);
    chk("out kept", {15'h0, ~t0}, {15'h0, tout});
    dir_chk(16'h0000, 16'h0005, 16'h0004, 16'h0000, "interval down");
    dir_chk(16'h0004, 16'h0000, 16'h0001, 16'h0001, "capture up");
    dir_chk(16'h0006, 16'h0005, 16'h0004, 16'h0001, "event down");
    dir_chk(16'h0008, 16'h0005, 16'h0004, 16'h0001, "one-count down");
    dir_chk(16'h000C, 16'h0000, 16'h0001, 16'h0001, "capture one-count up");
    hw_run(16'h0001, 1'b1, 1'b1, 16'h0000, "software only");
    hw_run(16'h0101, 1'b1, 1'b0, 16'h0010, "pin edge trigger");
    hw_run(16'h0241, 1'b1, 1'b0, 16'h0010, "both edge trigger");
    hw_run(16'h0401, 1'b0, 1'b1, 16'h0010, "master trigger");
    hw_run(16'h0401, 1'b1, 1'b0, 16'h0000, "master idle");
    retrig(16'h0009, 16'h0010, "retrigger on");
    retrig(16'h0008, 16'h0000, "retrigger off");
    wr_reg(4'h4, 16'h00FF);
    wr_reg(4'h5, 16'h0000);
    wr_reg(4'h6, 16'h00FF);
    wr_reg(4'h7, 16'h00FF);
    chk("init level", 16'h3, {14'h0, irq_level});
    rchk(4'h5, 16'h0000, "init request");
    final_report();
  end
endmodule
`default_nettype wire
